/* File: region_memory_access_control.sv */
`timescale 1ns/1ps
// Region based access checker with Avalon-MM configuration port
module region_memory_access_control
  import mpu_pkg::*;
#(
  parameter int unsigned REGIONS = NUM_REGIONS
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Core access request
  input wire mpu_pkg::access_type acc_in,
  input wire logic [DATA_W-1:0] mem_rdata_in,
  output logic acc_done_out,
  output logic acc_grant_out,
  output logic acc_fault_out,
  output logic mem_we_out,
  output logic mem_re_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] acc_rdata_out,
  input wire logic [DATA_W-1:0] acc_wdata_in,
  output logic [DATA_W-1:0] mem_wdata_out,
  // Level of the software driving the config bus
  input wire logic cfg_priv_in,
  // Avalon-MM slave
  input wire logic [REG_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out
);
  import mpu_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_DONE = 2'b11
  } acc_state_type;

  region_type region_ff [REGIONS];
  region_type nxt_region [REGIONS];
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [ST_W-1:0] status_ff, nxt_status;
  logic [ST_W-1:0] mask_ff, nxt_mask;
  logic [ADDR_W-1:0] fault_addr_ff, nxt_fault_addr;
  logic [3:0] fault_info_ff, nxt_fault_info;
  logic irq_ff, nxt_irq;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;

  acc_state_type state_ff, nxt_state;
  access_type req_ff, nxt_req;
  logic done_ff, nxt_done;
  logic grant_ff, nxt_grant;
  logic fault_ff, nxt_fault;
  logic we_ff, nxt_we;
  logic re_ff, nxt_re;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [DATA_W-1:0] ardata_ff, nxt_ardata;

  logic [REGIONS-1:0] hit;
  region_type sel;
  logic any_hit;
  logic region_allow;
  logic verdict_allow;
  logic verdict_miss;

  // Address match per region
  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : g_match
      assign hit[g] = region_ff[g].en && (req_ff.addr >= region_ff[g].base)
        && (req_ff.addr <= region_ff[g].limit);
    end
  endgenerate

  // Priority pick, later index overrides earlier
  always_comb begin
    sel = REGION_OFF_DEFAULT;
    any_hit = 1'b0;
    for (int i = 0; i < REGIONS; i++) begin
      if (hit[i]) begin
        sel = region_ff[i];
        any_hit = 1'b1;
      end
    end
  end

  perm_check u_perm (
    .ap_in(sel.ap),
    .exec_ok_in(sel.exec_ok),
    .priv_in(req_ff.priv),
    .kind_in(req_ff.kind),
    .allow_out(region_allow)
  );

  // Final verdict; control bits, region hit and attributes, level and access kind are the inputs
  always_comb begin
    verdict_miss = !any_hit;
    if (!ctrl_ff[CTRL_EN_BIT]) begin
      verdict_allow = 1'b1; // Checker off: pass-through
    end else if (any_hit) begin
      verdict_allow = region_allow;
    end else begin
      verdict_allow = req_ff.priv && ctrl_ff[CTRL_BG_BIT];
    end
  end

  // Access sequencer: capture, check, then issue or block
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_done = 1'b0;
    nxt_grant = 1'b0;
    nxt_fault = 1'b0;
    nxt_we = 1'b0;
    nxt_re = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_ardata = ardata_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (acc_in.valid) begin
          nxt_req = acc_in;
          nxt_wdata = acc_wdata_in;
          nxt_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Memory strobes only after verdict is known
        if (verdict_allow) begin
          nxt_we = (req_ff.kind == ACC_WRITE);
          nxt_re = (req_ff.kind != ACC_WRITE);
        end
        nxt_grant = verdict_allow;
        nxt_fault = !verdict_allow;
        nxt_state = ST_DONE;
      end
      ST_DONE: begin
        // Data returns only on grant, else zero
        nxt_ardata = grant_ff && re_ff ? mem_rdata_in : BUS_ZERO;
        nxt_grant = grant_ff;
        nxt_fault = fault_ff;
        nxt_done = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      req_ff <= '0;
      done_ff <= 1'b0;
      grant_ff <= 1'b0;
      fault_ff <= 1'b0;
      we_ff <= 1'b0;
      re_ff <= 1'b0;
      wdata_ff <= BUS_ZERO;
      ardata_ff <= BUS_ZERO;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      done_ff <= nxt_done;
      grant_ff <= nxt_grant;
      fault_ff <= nxt_fault;
      we_ff <= nxt_we;
      re_ff <= nxt_re;
      wdata_ff <= nxt_wdata;
      ardata_ff <= nxt_ardata;
    end
  end

  // Register bus decode
  logic bus_req;
  logic [7:0] reg_idx;
  logic [2:0] rsel;
  logic [1:0] rsub;
  logic rhit;
  logic fault_evt;
  logic bus_wr;
  logic region_wr;
  logic [DATA_W-1:0] attr_word [REGIONS];

  assign bus_req = (avs_read_in || avs_write_in) && !ack_ff;
  assign reg_idx = avs_address_in - OFF_REGION_BASE;
  assign rsel = reg_idx[6:4];
  assign rsub = reg_idx[3:2];
  // Offset window covers all eight slots, not only the lower four
  assign rhit = (avs_address_in >= OFF_REGION_BASE) && (reg_idx[7] == 1'b0)
    && (rsub != 2'h3);
  assign fault_evt = state_ff == ST_CHECK && !verdict_allow;
  // Writes land at the completing edge, the one with waitrequest low
  assign bus_wr = avs_write_in && ack_ff;
  assign region_wr = bus_wr && cfg_priv_in && rhit;

  // Per-region next value and read-back word
  generate
    for (g = 0; g < REGIONS; g++) begin : g_region
      assign attr_word[g] = {25'h0, region_ff[g].ap, 2'h0, !region_ff[g].exec_ok,
        region_ff[g].en};
      always_comb begin
        nxt_region[g] = region_ff[g];
        // Only a privileged write to this slot changes it
        if (region_wr && (rsel == 3'(g))) begin
          unique case (rsub)
            SUB_BASE: nxt_region[g].base = avs_writedata_in;
            SUB_LIMIT: nxt_region[g].limit = avs_writedata_in;
            default: begin
              nxt_region[g].en = avs_writedata_in[ATTR_EN_BIT];
              nxt_region[g].exec_ok = !avs_writedata_in[ATTR_XN_BIT];
              nxt_region[g].ap = ap_type'(avs_writedata_in[ATTR_AP_LSB +: AP_W]);
            end
          endcase
        end
      end
    end
  endgenerate

  // Config writes, reads and sticky status
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    nxt_fault_addr = fault_addr_ff;
    nxt_fault_info = fault_info_ff;
    nxt_rdata = BUS_ZERO;
    nxt_ack = bus_req; // One wait cycle per access
    // Region slots are written in their own per-slot logic
    if (bus_wr) begin
      if (avs_address_in == OFF_STATUS) begin
        nxt_status = status_ff & ~avs_writedata_in[ST_W-1:0];
      end else if (!cfg_priv_in) begin
        nxt_status[ST_CFG_BIT] = 1'b1;
      end else if (avs_address_in == OFF_CTRL) begin
        nxt_ctrl = avs_writedata_in[1:0];
      end else if (avs_address_in == OFF_MASK) begin
        nxt_mask = avs_writedata_in[ST_W-1:0];
      end
    end
    if (bus_req && avs_read_in) begin
      if (avs_address_in == OFF_CTRL) begin
        nxt_rdata = {30'h0, ctrl_ff};
      end else if (avs_address_in == OFF_STATUS) begin
        nxt_rdata = {29'h0, status_ff};
      end else if (avs_address_in == OFF_MASK) begin
        nxt_rdata = {29'h0, mask_ff};
      end else if (avs_address_in == OFF_FAULT_ADDR) begin
        nxt_rdata = fault_addr_ff;
      end else if (avs_address_in == OFF_FAULT_INFO) begin
        nxt_rdata = {28'h0, fault_info_ff};
      end else if (rhit) begin
        unique case (rsub)
          SUB_BASE: nxt_rdata = region_ff[rsel].base;
          SUB_LIMIT: nxt_rdata = region_ff[rsel].limit;
          default: nxt_rdata = attr_word[rsel];
        endcase
      end
    end
    // Events after clear so a same-cycle set wins
    if (fault_evt) begin
      nxt_status[ST_PERM_BIT] = 1'b1;
      nxt_status[ST_MISS_BIT] = status_ff[ST_MISS_BIT] | verdict_miss;
      nxt_fault_addr = req_ff.addr;
      nxt_fault_info = {req_ff.priv, verdict_miss, req_ff.kind};
    end
    nxt_irq = |(nxt_status & mask_ff);
  end

  // Region state: defaults stand in for manufacturing values
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < REGIONS; i++) begin
        region_ff[i] <= (i == 0) ? REGION0_DEFAULT : REGION_OFF_DEFAULT;
      end
      ctrl_ff <= CTRL_RESET;
      mask_ff <= '0;
      status_ff <= '0;
      fault_addr_ff <= '0;
      fault_info_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= BUS_ZERO;
      ack_ff <= 1'b0;
    end else begin
      region_ff <= nxt_region;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
      fault_addr_ff <= nxt_fault_addr;
      fault_info_ff <= nxt_fault_info;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end

  // Waitrequest raised until the registered answer is ready
  logic wait_ff, nxt_wait;
  always_comb begin
    nxt_wait = !((avs_read_in || avs_write_in) && !ack_ff);
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= nxt_wait;
    end
  end

  assign acc_done_out = done_ff;
  assign acc_grant_out = grant_ff;
  assign acc_fault_out = fault_ff;
  assign mem_we_out = we_ff;
  assign mem_re_out = re_ff;
  assign mem_addr_out = req_ff.addr;
  assign mem_wdata_out = wdata_ff;
  assign acc_rdata_out = ardata_ff;
  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign irq_out = irq_ff;
endmodule

/* File: mpu_pkg.sv */
// Shared constants, types and register map of the region access checker
package mpu_pkg;
  localparam int unsigned NUM_REGIONS = 8;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h0c;
  localparam logic [7:0] OFF_FAULT_INFO = 8'h10;
  localparam logic [7:0] OFF_REGION_BASE = 8'h40;
  // Each region: base, limit, attr words, 16-byte stride
  localparam logic [7:0] REGION_STRIDE = 8'h10;
  localparam logic [1:0] SUB_BASE = 2'h0;
  localparam logic [1:0] SUB_LIMIT = 2'h1;
  localparam logic [1:0] SUB_ATTR = 2'h2;

  // Attribute word fields
  localparam int unsigned ATTR_EN_BIT = 0;
  localparam int unsigned ATTR_XN_BIT = 1;
  localparam int unsigned ATTR_AP_LSB = 4;
  localparam int unsigned AP_W = 3;

  // Control bits
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_BG_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Status bits
  localparam int unsigned ST_PERM_BIT = 0;
  localparam int unsigned ST_MISS_BIT = 1;
  localparam int unsigned ST_CFG_BIT = 2;
  localparam int unsigned ST_W = 3;

  localparam logic [DATA_W-1:0] BUS_ZERO = 32'h0000_0000;

  // Permission encodings
  typedef enum logic [2:0] {
    AP_NONE = 3'h0,
    AP_PRW = 3'h1,
    AP_PRW_URO = 3'h2,
    AP_FULL = 3'h3,
    AP_PRO = 3'h4,
    AP_RO = 3'h5
  } ap_type;

  typedef enum logic [1:0] {
    ACC_READ = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_EXEC = 2'h2
  } acc_type;

  typedef struct packed {
    logic en;
    logic exec_ok;
    ap_type ap;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] limit;
  } region_type;

  // Manufacturing defaults: region 0 full span, full access, others off
  localparam region_type REGION0_DEFAULT = '{en: 1'b1, exec_ok: 1'b1, ap: AP_FULL,
    base: 32'h0000_0000, limit: 32'hffff_ffff};
  localparam region_type REGION_OFF_DEFAULT = '{en: 1'b0, exec_ok: 1'b0, ap: AP_NONE,
    base: 32'h0000_0000, limit: 32'h0000_0000};

  typedef struct packed {
    logic valid;
    logic priv;
    acc_type kind;
    logic [ADDR_W-1:0] addr;
  } access_type;

  typedef struct packed {
    logic grant;
    logic fault;
    logic miss;
  } verdict_type;
endpackage

/* File: perm_check.sv */
`timescale 1ns/1ps
// Combinational permission decoder for one resolved region attribute
module perm_check
  import mpu_pkg::*;
(
  input wire mpu_pkg::ap_type ap_in,
  input wire logic exec_ok_in,
  input wire logic priv_in,
  input wire mpu_pkg::acc_type kind_in,
  output logic allow_out
);
  logic rd_ok;
  logic wr_ok;

  // Permission table, separate read and write rights per level
  always_comb begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    unique case (ap_in)
      AP_NONE: begin
        rd_ok = 1'b0;
      end
      AP_PRW: begin
        rd_ok = priv_in;
        wr_ok = priv_in;
      end
      AP_PRW_URO: begin
        rd_ok = 1'b1;
        wr_ok = priv_in;
      end
      AP_FULL: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      AP_PRO: begin
        rd_ok = priv_in;
      end
      AP_RO: begin
        rd_ok = 1'b1;
      end
      default: begin
        rd_ok = 1'b0; // Unused codes deny everything
      end
    endcase
  end

  // Execute needs read right plus fetch enable
  always_comb begin
    unique case (kind_in)
      ACC_READ: allow_out = rd_ok;
      ACC_WRITE: allow_out = wr_ok;
      ACC_EXEC: allow_out = rd_ok && exec_ok_in;
      default: allow_out = 1'b0;
    endcase
  end
endmodule

/* File: mem_model.sv */
// Memory model standing behind the access checker
`timescale 1ns/1ps
module mem_model
  import mpu_pkg::*;
(
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic re_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  output logic [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] mem_ff [16];
  initial begin
    foreach (mem_ff[i]) mem_ff[i] = 32'h0;
  end
  // Writes land at the edge that sees the strobe
  always @(posedge clk_in) begin
    if (we_in) mem_ff[addr_in[5:2]] <= wdata_in;
  end
  // Data stands while the read strobe is high; inverse otherwise, so late samples show
  assign rdata_out = re_in ? mem_ff[addr_in[5:2]] : ~mem_ff[addr_in[5:2]];
endmodule

/* File: region_memory_access_control_asserts.sv */
// Port level checks of the region access checker
`timescale 1ns/1ps
module region_memory_access_control_asserts
  import mpu_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic acc_done_out,
  input wire logic acc_grant_out,
  input wire logic acc_fault_out,
  input wire logic mem_we_out,
  input wire logic mem_re_out,
  input wire logic [DATA_W-1:0] acc_rdata_out,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Verdict and strobe relations
  property p_excl; !(acc_grant_out && acc_fault_out); endproperty
  a_excl: assert property (p_excl) else $error("grant with fault");
  property p_we_grant; mem_we_out |-> acc_grant_out; endproperty
  a_we_grant: assert property (p_we_grant) else $error("write strobe ungranted");
  property p_re_grant; $rose(mem_re_out) |-> acc_grant_out ##1 acc_done_out; endproperty
  a_re_grant: assert property (p_re_grant) else $error("read strobe order");
  property p_strobe_done; (mem_we_out || mem_re_out) |=> acc_done_out; endproperty
  a_strobe_done: assert property (p_strobe_done) else $error("no done after strobe");
  property p_verdict; acc_done_out |-> (acc_grant_out != acc_fault_out); endproperty
  a_verdict: assert property (p_verdict) else $error("done without verdict");
  property p_fault_zero; acc_done_out && acc_fault_out |-> acc_rdata_out == BUS_ZERO;
  endproperty
  a_fault_zero: assert property (p_fault_zero) else $error("denied data leaked");
  property p_done_pulse; acc_done_out |=> !acc_done_out; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  // Config bus answers one cycle after the request, for one cycle
  property p_ack; $rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out ##1
    avs_waitrequest_out; endproperty
  a_ack: assert property (p_ack) else $error("config answer timing");
  c_fault: cover property (acc_done_out && acc_fault_out);
  c_write: cover property (mem_we_out);
  c_irq: cover property (irq_out);
endmodule
bind region_memory_access_control region_memory_access_control_asserts chk (
  .ref_clk_in, .rst_n_in, .acc_done_out, .acc_grant_out, .acc_fault_out, .mem_we_out,
  .mem_re_out, .acc_rdata_out, .avs_read_in, .avs_write_in, .avs_waitrequest_out, .irq_out);

/* File: region_memory_access_control_tb_top.sv */
// Self-checking bench of the region access checker
`timescale 1ns/1ps
module region_memory_access_control_tb_top;
  import mpu_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  access_type acc_in = '0;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] acc_wdata = 32'h0;
  logic [DATA_W-1:0] acc_rdata;
  logic [DATA_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] mem_addr;
  logic acc_done;
  logic acc_grant;
  logic acc_fault;
  logic mem_we;
  logic mem_re;
  logic cfg_priv = 1'b1;
  logic [REG_ADDR_W-1:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic g;
  logic f;
  logic [DATA_W-1:0] q;
  int mismatches = 0;
  int checks_done = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  region_memory_access_control dut (.ref_clk_in, .rst_n_in, .acc_in, .mem_rdata_in(mem_rdata),
    .acc_done_out(acc_done), .acc_grant_out(acc_grant), .acc_fault_out(acc_fault),
    .mem_we_out(mem_we), .mem_re_out(mem_re), .mem_addr_out(mem_addr),
    .acc_rdata_out(acc_rdata), .acc_wdata_in(acc_wdata), .mem_wdata_out(mem_wdata),
    .cfg_priv_in(cfg_priv), .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest), .irq_out(irq));
  mem_model mem (.clk_in(ref_clk_in), .we_in(mem_we), .re_in(mem_re), .addr_in(mem_addr),
    .wdata_in(mem_wdata), .rdata_out(mem_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // One access; verdict and data taken with done
  task automatic access(input logic p, input acc_type k, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge ref_clk_in);
    acc_in <= '{valid: 1'b1, priv: p, kind: k, addr: a};
    acc_wdata <= d;
    @(posedge ref_clk_in);
    acc_in.valid <= 1'b0;
    while (acc_done !== 1'b1) begin
      @(posedge ref_clk_in);
    end
    g = acc_grant;
    f = acc_fault;
    q = acc_rdata;
  endtask
  // Own reading of the permission table
  function automatic logic allowed(input int ap, input logic p, input logic w);
    case (ap)
      1: return p;
      2: return p || !w;
      3: return 1'b1;
      4: return p && !w;
      5: return !w;
      default: return 1'b0;
    endcase
  endfunction
  task automatic t_reset_values();
    rreg(8'h00, 32'h3);
    rreg(8'h44, 32'hffff_ffff);
    rreg(8'h48, 32'h31);
    rreg(8'hfc, 32'h0);
  endtask
  task automatic t_perm_table();
    bus(1'b1, 8'h50, 32'h100);
    bus(1'b1, 8'h54, 32'h1ff);
    for (int ap = 0; ap < 7; ap++) begin
      bus(1'b1, 8'h58, 32'(ap * 16 + 1));
      for (int i = 0; i < 4; i++) begin
        access(i[1], i[0] ? ACC_WRITE : ACC_READ, 32'h180, 32'h0);
        check(g, allowed(ap, i[1], i[0]));
        check(f, !allowed(ap, i[1], i[0]));
      end
    end
    bus(1'b1, 8'h58, 32'h33);
    access(1'b1, ACC_EXEC, 32'h180, 32'h0);
    check(g, 1'b0);
    bus(1'b1, 8'h58, 32'h31);
    access(1'b0, ACC_EXEC, 32'h180, 32'h0);
    check(g, 1'b1);
  endtask
  task automatic t_priority();
    bus(1'b1, 8'h60, 32'h100);
    bus(1'b1, 8'h64, 32'h1ff);
    bus(1'b1, 8'h68, 32'h01);
    access(1'b1, ACC_READ, 32'h180, 32'h0);
    check(g, 1'b0);
    bus(1'b1, 8'h68, 32'h0);
    access(1'b0, ACC_READ, 32'h180, 32'h0);
    check(g, 1'b1);
    bus(1'b1, 8'hb0, 32'h100);
    bus(1'b1, 8'hb4, 32'h1ff);
    bus(1'b1, 8'hb8, 32'h01);
    rreg(8'hb8, 32'h01);
    access(1'b1, ACC_READ, 32'h180, 32'h0);
    check(g, 1'b0);
    bus(1'b1, 8'hb8, 32'h0);
  endtask
  task automatic t_denied_write();
    access(1'b1, ACC_WRITE, 32'h180, 32'ha5a5_0001);
    bus(1'b1, 8'h58, 32'h21);
    access(1'b0, ACC_WRITE, 32'h180, 32'h5a5a_0002);
    check(g, 1'b0);
    access(1'b0, ACC_READ, 32'h180, 32'h0);
    check(q, 32'ha5a5_0001);
    bus(1'b1, 8'h58, 32'h11);
    access(1'b0, ACC_READ, 32'h180, 32'h0);
    check(q, 32'h0);
    access(1'b1, ACC_READ, 32'h180, 32'h0);
    check(q, 32'ha5a5_0001);
  endtask
  task automatic t_miss();
    bus(1'b1, 8'h48, 32'h0);
    access(1'b0, ACC_READ, 32'h800, 32'h0);
    check(g, 1'b0);
    access(1'b1, ACC_READ, 32'h800, 32'h0);
    check(g, 1'b1);
    bus(1'b1, 8'h00, 32'h1);
    access(1'b1, ACC_READ, 32'h800, 32'h0);
    check(g, 1'b0);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h48, 32'h31);
  endtask
  // Unprivileged config writes other than status clears bounce and set status bit 2; irq rises only once the mask enables it
  task automatic t_cfg_irq();
    bus(1'b1, 8'h04, 32'h7);
    cfg_priv <= 1'b0;
    bus(1'b1, 8'h48, 32'h0);
    rreg(8'h48, 32'h31);
    rreg(8'h04, 32'h4);
    check(irq, 1'b0);
    cfg_priv <= 1'b1;
    bus(1'b1, 8'h08, 32'h4);
    repeat (3) @(posedge ref_clk_in);
    check(irq, 1'b1);
    bus(1'b1, 8'h04, 32'h4);
    repeat (3) @(posedge ref_clk_in);
    check(irq, 1'b0);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset_values();
    t_perm_table();
    t_priority();
    t_denied_write();
    t_miss();
    t_cfg_irq();
    print_verdict();
  end
endmodule
